//--- mrp_pkg.sv
// Purpose: Shared constants and carriers for the multi-record DRAM packer.
// Assumes: 256-bit memory words, 64-byte header, four 16-bit lanes in.
// Notes:   Page size is fixed here; a different memory changes PAGE_WORDS.
package mrp_pkg;

  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned SAMPLE_W    = 16;
  localparam int unsigned DW          = 256;
  localparam int unsigned AW          = 24;
  localparam int unsigned HDR_BYTES   = 64;
  localparam int unsigned HDR_WORDS   = HDR_BYTES * 8 / DW;
  localparam int unsigned PAGE_WORDS  = 16;
  localparam int unsigned PAGE_SHIFT  = 4;
  localparam int unsigned PACK12_W    = 12;
  localparam int unsigned PACK14_W    = 16;
  localparam int unsigned CNT_W       = 24;
  localparam logic [15:0] HDR_MARK    = 16'h5a5a;

  // Sample width selection.
  typedef enum logic [1:0] {
    MRP_FMT_16,
    MRP_FMT_12,
    MRP_FMT_14
  } mrp_fmt_t;

  // One beat of samples from all channels.
  typedef struct packed {
    logic                         valid;
    logic [NUM_CH*SAMPLE_W-1:0]   data;
  } mrp_beat_t;

  // One memory write request.
  typedef struct packed {
    logic          valid;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } mrp_wr_t;

endpackage : mrp_pkg

//--- mrp_packer.sv
// Purpose: Packs interleaved channel samples densely into memory words.
// Assumes: One beat per cycle at most; flush emits a partly filled word.
// Notes:   Unused bit positions of a flushed word read as zero.
`timescale 1ns/1ps
module mrp_packer (
  input  wire logic              clk_sys_i, // System clock.
  input  wire logic              srst_i,    // Synchronous reset.
  input  wire mrp_pkg::mrp_fmt_t fmt_i,     // Sample width mode.
  input  wire mrp_pkg::mrp_beat_t beat_i,   // Interleaved beat in.
  input  wire logic              flush_i,   // Emit partial word.
  output logic                   word_vld_o, // Packed word ready.
  output logic [mrp_pkg::DW-1:0] word_o     // Packed word.
);

  localparam int unsigned ACC_W = 2 * mrp_pkg::DW;
  localparam int unsigned PTR_W = 10;

  logic [ACC_W-1:0] acc;
  logic [PTR_W-1:0] fill;
  logic [mrp_pkg::NUM_CH*mrp_pkg::SAMPLE_W-1:0] squeezed;
  logic [PTR_W-1:0] beat_bits;
  logic [ACC_W-1:0] merged;

  // Width that each sample takes in memory.
  function automatic logic [4:0] lane_w(input mrp_pkg::mrp_fmt_t f);
    case (f)
      mrp_pkg::MRP_FMT_12: lane_w = 5'(mrp_pkg::PACK12_W);
      mrp_pkg::MRP_FMT_14: lane_w = 5'(mrp_pkg::PACK14_W);
      default:             lane_w = 5'(mrp_pkg::SAMPLE_W);
    endcase
  endfunction : lane_w

  // Channels sit side by side, each trimmed to its stored width.
  always_comb begin
    squeezed = '0;
    for (int c = 0; c < mrp_pkg::NUM_CH; c++) begin
      if (fmt_i == mrp_pkg::MRP_FMT_12) begin
        squeezed[c*mrp_pkg::PACK12_W +: mrp_pkg::PACK12_W] =
          beat_i.data[c*mrp_pkg::SAMPLE_W +: mrp_pkg::PACK12_W]; // RL4
      end else begin
        squeezed[c*mrp_pkg::SAMPLE_W +: mrp_pkg::SAMPLE_W] =
          beat_i.data[c*mrp_pkg::SAMPLE_W +: mrp_pkg::SAMPLE_W]; // RL7
      end
    end
    beat_bits = PTR_W'(mrp_pkg::NUM_CH * lane_w(fmt_i)); // RL6
    // Accumulator with the new beat appended above the filled bits.
    merged    = acc | (ACC_W'(squeezed) << fill); // RL4
  end

  // Bits spill past a word boundary into the next word without a gap.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      acc        <= '0;
      fill       <= '0;
      word_vld_o <= 1'b0;
      word_o     <= '0;
    end else begin
      word_vld_o <= 1'b0;
      if (beat_i.valid) begin
        if (32'(fill) + 32'(beat_bits) >= mrp_pkg::DW) begin
          word_vld_o <= 1'b1;
          word_o     <= merged[mrp_pkg::DW-1:0]; // RL4
          acc  <= merged >> mrp_pkg::DW;
          fill <= PTR_W'(32'(fill) + 32'(beat_bits) - mrp_pkg::DW);
        end else begin
          acc  <= merged;
          fill <= fill + beat_bits;
        end
      end else if (flush_i && fill != '0) begin
        word_vld_o <= 1'b1;
        word_o     <= acc[mrp_pkg::DW-1:0];
        acc        <= '0;
        fill       <= '0;
      end
    end
  end

endmodule : mrp_packer

//--- mrp_dram_packer.sv
// Purpose: Writes triggered multi-channel records into DRAM with headers.
// Assumes: Memory accepts one word per cycle when mem_rdy_i is high.
// Notes:   A stalled memory drops data words; no buffer sits in front of it.
//
// Behaviour
// RL1 - Each record starts with 64-byte header
// RL2 - Pad record up to memory word width
// RL3 - Records occupy whole pages of wide words
// RL4 - Twelve-bit samples packed with no gaps
// RL5 - Data ring keeps pre-trigger samples
// RL6 - All channels written together, interleaved
// RL7 - Fourteen-bit samples stored in sixteen bits
// RL8 - Header holds the trigger information
// RL9 - Reader unpacks words and splits channels
// RL10 - Reader realigns by trigger, trims length
// RL11 - Address wraps in region, captured at trigger
// RL12 - Stop after post-trigger count, next page slot
`timescale 1ns/1ps
module mrp_dram_packer (
  input  wire logic                  clk_sys_i,  // System clock.
  input  wire logic                  srst_i,     // Synchronous reset.
  input  wire logic                  arm_i,      // Start a record.
  input  wire mrp_pkg::mrp_fmt_t     fmt_i,      // Sample width mode.
  input  wire logic [mrp_pkg::CNT_W-1:0] ring_words_i, // Data ring words.
  input  wire logic [mrp_pkg::CNT_W-1:0] post_beats_i, // Post-trigger beats.
  input  wire logic [mrp_pkg::AW-1:0] base_addr_i, // First record slot.
  input  wire mrp_pkg::mrp_beat_t    beat_i,     // Interleaved samples.
  input  wire logic                  trig_i,     // Trigger pulse.
  input  wire logic                  mem_rdy_i,  // Memory accepts.
  output mrp_pkg::mrp_wr_t           mem_wr_o,   // Memory write.
  output logic                       busy_o,     // Record in progress.
  output logic                       done_o,     // Record finished pulse.
  output logic [15:0]                rec_cnt_o   // Records stored.
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_PRE,
    ST_POST,
    ST_FLUSH,
    ST_HDR
  } mrp_state_t;

  mrp_state_t state;
  logic [mrp_pkg::AW-1:0]    slot_base;
  logic [mrp_pkg::CNT_W-1:0] wptr;
  logic [mrp_pkg::CNT_W-1:0] trig_ptr;
  logic [mrp_pkg::CNT_W-1:0] post_cnt;
  logic                      wrapped;
  logic [1:0]                hdr_idx;
  logic                      pk_vld;
  logic [mrp_pkg::DW-1:0]    pk_word;
  logic                      flush;
  mrp_pkg::mrp_beat_t        beat_g;
  logic [mrp_pkg::DW-1:0]    hdr_word;
  logic [mrp_pkg::CNT_W-1:0] rec_words;
  logic                      hdr_go;

  // Data words begin after the header words of the slot.
  function automatic logic [mrp_pkg::AW-1:0] data_addr(
      input logic [mrp_pkg::AW-1:0]    base,
      input logic [mrp_pkg::CNT_W-1:0] ptr);
    data_addr = base + mrp_pkg::AW'(mrp_pkg::HDR_WORDS) + ptr; // RL1
  endfunction : data_addr

  // Beats only count while a record is open.
  always_comb begin
    beat_g.valid = beat_i.valid && (state == ST_PRE || state == ST_POST);
    beat_g.data  = beat_i.data;
    flush        = (state == ST_FLUSH);
    // A partial word from the flush lands in the first header cycle; the
    // header step waits for it so that neither word is lost on the port.
    hdr_go       = (state == ST_HDR) && mem_rdy_i && !pk_vld; // RL1
  end

  mrp_packer u_packer (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .fmt_i      (fmt_i),
    .beat_i     (beat_g),
    .flush_i    (flush),
    .word_vld_o (pk_vld),
    .word_o     (pk_word)
  );

  // Header carries trigger pointer, wrap flag, ring size and format.
  always_comb begin
    hdr_word = '0;
    if (hdr_idx == 2'h0) begin
      hdr_word[15:0]   = mrp_pkg::HDR_MARK;
      hdr_word[47:24]  = trig_ptr; // RL8
      hdr_word[48]     = wrapped;
      hdr_word[55:50]  = 6'(fmt_i);
      hdr_word[87:64]  = ring_words_i;
      hdr_word[119:96] = post_beats_i;
      hdr_word[143:128] = rec_cnt_o;
    end
  end

  // Slot size in whole pages: header plus ring, rounded up to a page.
  always_comb begin
    rec_words = ring_words_i + mrp_pkg::CNT_W'(mrp_pkg::HDR_WORDS)
              + mrp_pkg::CNT_W'(mrp_pkg::PAGE_WORDS - 1); // RL3
    rec_words = (rec_words >> mrp_pkg::PAGE_SHIFT)
                << mrp_pkg::PAGE_SHIFT; // RL3
  end

  // Record sequencing: pre-trigger ring, post count, flush, header.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state    <= ST_IDLE;
      post_cnt <= '0;
      hdr_idx  <= '0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (arm_i) begin
            state <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (trig_i) begin
            post_cnt <= '0;
            state    <= (post_beats_i == '0) ? ST_FLUSH : ST_POST;
          end
        end
        ST_POST: begin
          if (beat_i.valid) begin
            post_cnt <= post_cnt + 1'b1;
            if (post_cnt + 1'b1 >= post_beats_i) begin
              state <= ST_FLUSH; // RL12
            end
          end
        end
        ST_FLUSH: begin
          hdr_idx <= '0;
          state   <= ST_HDR; // RL2
        end
        ST_HDR: begin
          if (hdr_go) begin
            hdr_idx <= hdr_idx + 1'b1;
            if (32'(hdr_idx) == mrp_pkg::HDR_WORDS - 1) begin
              state  <= ST_IDLE;
              done_o <= 1'b1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Ring write pointer and trigger capture.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      wptr     <= '0;
      wrapped  <= 1'b0;
      trig_ptr <= '0;
    end else begin
      if (state == ST_IDLE && arm_i) begin
        wptr    <= '0;
        wrapped <= 1'b0;
      end else if (pk_vld) begin
        if (wptr + 1'b1 >= ring_words_i) begin
          wptr    <= '0; // RL11
          wrapped <= 1'b1; // RL5
        end else begin
          wptr <= wptr + 1'b1; // RL5
        end
      end
      if (state == ST_PRE && trig_i) begin
        trig_ptr <= wptr; // RL11
      end
    end
  end

  // Slot base advances by whole pages once a record completes.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      slot_base <= '0;
      rec_cnt_o <= '0;
    end else if (state == ST_IDLE && arm_i && rec_cnt_o == '0) begin
      slot_base <= base_addr_i;
    end else if (hdr_go && 32'(hdr_idx) == mrp_pkg::HDR_WORDS - 1) begin
      slot_base <= slot_base + mrp_pkg::AW'(rec_words); // RL12
      rec_cnt_o <= rec_cnt_o + 1'b1;
    end
  end

  // Memory writes: data words as packed, header words at the end.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mem_wr_o <= '0;
    end else if (pk_vld) begin
      mem_wr_o.valid <= 1'b1; // RL6
      mem_wr_o.addr  <= data_addr(slot_base, wptr); // RL5
      mem_wr_o.data  <= pk_word;
    end else if (hdr_go) begin
      mem_wr_o.valid <= 1'b1;
      mem_wr_o.addr  <= slot_base + mrp_pkg::AW'(hdr_idx); // RL1
      mem_wr_o.data  <= hdr_word; // RL8
    end else begin
      mem_wr_o.valid <= 1'b0;
    end
  end

  assign busy_o = (state != ST_IDLE);

endmodule : mrp_dram_packer

//--- mrp_monitor.sv
// Purpose: Port assertions for the record packer.
// Assumes: One clock; srst_i masks every check.
// Notes: Header writes wait for ready, data writes do not.
`timescale 1ns/1ps
module mrp_monitor (
  input wire logic                   clk_sys_i,   // Clock.
  input wire logic                   srst_i,      // Reset.
  input wire logic                   arm_i,       // Arm.
  input wire logic                   mem_rdy_i,   // Ready.
  input wire logic [mrp_pkg::AW-1:0] base_addr_i, // Base.
  input wire mrp_pkg::mrp_wr_t       mem_wr_o,    // Write.
  input wire logic                   busy_o,      // Busy.
  input wire logic                   done_o,      // Done.
  input wire logic [15:0]            rec_cnt_o    // Count.
);
  // Every check lives in the one clock domain.
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  a_arm_starts: assert property (!busy_o && arm_i |=> busy_o)
    else $error("arm not taken");
  a_done_single: assert property (done_o |=> !done_o)
    else $error("done too long");
  a_count_step: assert property ($changed(rec_cnt_o) |->
    rec_cnt_o == $past(rec_cnt_o) + 16'h1) else $error("count jump");
  a_count_cause: assert property ($changed(rec_cnt_o) |->
    done_o || $past(done_o)) else $error("count without done");
  a_write_busy: assert property (mem_wr_o.valid |->
    busy_o || $past(busy_o) || $past(busy_o, 2)) else $error("idle write");
  a_addr_floor: assert property (mem_wr_o.valid |->
    mem_wr_o.addr >= base_addr_i) else $error("write below base");
  a_done_header: assert property (done_o |-> mem_wr_o.valid ||
    $past(mem_wr_o.valid) || $past(mem_wr_o.valid, 2))
    else $error("done without header");
  a_header_ready: assert property (done_o |-> $past(mem_rdy_i) ||
    $past(mem_rdy_i, 2) || $past(mem_rdy_i, 3)) else $error("header stall");
  c_record: cover property (done_o);
  c_stalled: cover property (busy_o && !mem_rdy_i);
  c_lost_write: cover property (mem_wr_o.valid && !mem_rdy_i);
endmodule : mrp_monitor

//--- mrp_mem_model.sv
// Purpose: Memory beside the packer's write port.
// Assumes: A word lands only while ready is high.
// Notes: Stalls come from the bench; stalled writes are lost.
`timescale 1ns/1ps
module mrp_mem_model (
  input  wire logic             clk_sys_i, // Clock.
  input  wire mrp_pkg::mrp_wr_t wr_i,      // Write request.
  input  wire logic             stall_i,   // Hold off writes.
  output logic                  rdy_o      // Accepts a word.
);
  logic [mrp_pkg::DW-1:0] mem [int]; // Sparse store the reader unpacks.
  assign rdy_o = !stall_i;
  // Like real memory, a write offered while stalled is dropped.
  always @(posedge clk_sys_i) begin
    if (wr_i.valid && rdy_o) mem[int'(wr_i.addr)] = wr_i.data;
  end
endmodule : mrp_mem_model

//--- mrp_dram_packer_tb.sv
// Purpose: Self-checking bench for the record packer.
// Assumes: Data words written while stalled are lost, so only a stalled record's header is read.
// Notes: Expected words are rebuilt bit by bit from the samples.
`timescale 1ns/1ps
module mrp_dram_packer_tb;
  typedef struct packed {int f; int pre; int p; int r; int tp;} mrp_row_t;
  mrp_row_t rows [3] = '{'{0, 8, 8, 4, 2}, '{1, 20, 7, 3, 3},
                         '{2, 2, 4, 20, 0}};
  logic clk_sys_i = 0, srst_i = 1, arm = 0, trig = 0, stall = 0;
  logic [23:0] ring = 24'h4, post = 24'h4, base = 24'h100, slot;
  mrp_pkg::mrp_fmt_t fmt = mrp_pkg::MRP_FMT_16;
  mrp_pkg::mrp_beat_t beat = '0;
  mrp_pkg::mrp_wr_t wr;
  logic rdy, busy, done;
  logic [15:0] cnt;
  int miscompares = 0, tests_run = 0;
  // Free-running 100 MHz clock.
  always #5 clk_sys_i = ~clk_sys_i;
  mrp_dram_packer i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .arm_i(arm), .fmt_i(fmt), .ring_words_i(ring), .post_beats_i(post),
    .base_addr_i(base), .beat_i(beat), .trig_i(trig), .mem_rdy_i(rdy),
    .mem_wr_o(wr), .busy_o(busy), .done_o(done), .rec_cnt_o(cnt));
  mrp_mem_model i_mem (.clk_sys_i(clk_sys_i), .wr_i(wr), .stall_i(stall),
    .rdy_o(rdy));
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [15:0] smp(int k, int c);
    return {4'h0, 8'(k), 4'(c)};
  endfunction : smp
  // Word i of the dense channel-interleaved stream, zero past the end.
  function automatic logic [255:0] xw(int i, int n, int sw);
    logic [255:0] w;
    logic [15:0] s;
    int g;
    w = '0;
    for (int b = 0; b < 256; b++) begin
      g = 256 * i + b;
      s = smp(g / (4 * sw), (g % (4 * sw)) / sw);
      if (g / (4 * sw) < n) w[b] = s[g % sw];
    end
    return w;
  endfunction : xw
  // One record: arm, pre beats, trigger, post beats, then read back.
  task automatic rec(input mrp_row_t w, input int st);
    int n, sw, nw, i, k, tw;
    logic [15:0] idx;
    n = w.pre + w.p;
    sw = (w.f == 1) ? 12 : 16;
    nw = (n * 4 * sw + 255) / 256;
    idx = cnt;
    fmt <= mrp_pkg::mrp_fmt_t'(w.f);
    ring <= 24'(w.r);
    post <= 24'(w.p);
    arm <= 1'b1;
    @(posedge clk_sys_i);
    arm <= 1'b0;
    for (k = 0; k < n; k++) begin
      if (k == w.pre) begin
        beat.valid <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        trig <= 1'b1;
        @(posedge clk_sys_i);
        trig <= 1'b0;
      end
      beat <= {1'b1, smp(k, 3), smp(k, 2), smp(k, 1), smp(k, 0)};
      @(posedge clk_sys_i);
    end
    beat.valid <= 1'b0;
    stall <= st[0];
    for (k = 0; k < 20 * st; k++) begin
      @(negedge clk_sys_i);
      if (done !== 1'b0) chk(256'h1, 256'h0);
    end
    @(posedge clk_sys_i);
    stall <= 1'b0;
    for (k = 0; done !== 1'b1 && k < 300; k++) @(negedge clk_sys_i);
    chk(256'(k < 300), 256'h1);
    repeat (2) @(posedge clk_sys_i);
    chk(i_mem.mem[int'(slot)], {112'h0, idx, 8'h0, 24'(w.p), 8'h0,
      24'(w.r), 8'h0, 6'(w.f), 1'b0, nw >= w.r, 24'(w.tp % w.r), 8'h0,
      mrp_pkg::HDR_MARK});
    chk(256'(cnt), 256'(idx + 16'h1));
    // Reader view: the header pointer leads to the first post-trigger word.
    tw = int'(i_mem.mem[int'(slot)][47:24]);
    if (st == 0 && nw - w.tp <= w.r) begin
      chk(i_mem.mem[int'(slot) + 2 + tw], xw(w.tp, n, sw));
    end
    for (k = 0; k < w.r && k < nw && st == 0; k++) begin
      i = k + w.r * ((nw - 1 - k) / w.r);
      chk(i_mem.mem[int'(slot) + 2 + k], xw(i, n, sw));
    end
    slot = slot + 24'((w.r + 17) / 16 * 16);
    $display("record with format %0d done", w.f);
  endtask : rec
  task automatic complete_run;
    $display("%0d compared, %0d mismatched", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Main sequence: table of records, then idle trigger, stall and reset.
  initial begin
    slot = base;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(negedge clk_sys_i);
    chk(256'({busy, done, wr.valid, cnt}), 256'h0);
    $display("power-up reset test done");
    @(posedge clk_sys_i);
    for (int j = 0; j < 3; j++) rec(rows[j], 0);
    trig <= 1'b1;
    beat <= {1'b1, 64'h0};
    @(posedge clk_sys_i);
    trig <= 1'b0;
    beat.valid <= 1'b0;
    repeat (3) @(negedge clk_sys_i);
    chk(256'({busy, wr.valid, cnt}), 256'h3);
    $display("idle trigger test done");
    @(posedge clk_sys_i);
    rec('{0, 4, 4, 2, 1}, 1);
    arm <= 1'b1;
    beat <= {1'b1, 64'h1};
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b1;
    arm <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    beat.valid <= 1'b0;
    @(negedge clk_sys_i);
    chk(256'({busy, done, wr.valid, cnt}), 256'h0);
    slot = base;
    $display("mid-run reset test done");
    @(posedge clk_sys_i);
    rec(rows[0], 0);
    complete_run();
  end
  // Cuts a hang short; the run needs well under 2000 cycles.
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule : mrp_dram_packer_tb
bind mrp_dram_packer mrp_monitor i_mon (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .arm_i(arm_i), .mem_rdy_i(mem_rdy_i),
  .base_addr_i(base_addr_i), .mem_wr_o(mem_wr_o), .busy_o(busy_o),
  .done_o(done_o), .rec_cnt_o(rec_cnt_o));
